// ---- rtl/lqt_link_quality_threshold_access.sv ----
/*
  Link quality threshold access: threshold data register with sampling of the
  adapted receiver parameters, plus the warning and control register of the
  monitor that uses the thresholds.
  Assumes a management frame decoder on the same clock that gives one-cycle
  read and write strobes, and parameter values from the DSP on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lqt_link_quality_threshold_access
  import lqt_pkg::*;
(
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic [LQT_ADDR_W-1:0]            reg_addr_i,
  input  wire logic                             reg_wr_i,
  input  wire logic [LQT_DATA_W-1:0]            reg_wdata_i,
  input  wire logic                             reg_rd_i,
  output logic      [LQT_DATA_W-1:0]            reg_rdata_o,
  output logic                                  reg_rvalid_o,
  input  wire logic                             power_down_i,
  input  wire logic                             link_100_valid_i,
  input  wire logic [LQT_NUM_PARAM*LQT_THR_W-1:0] param_value_i,
  output logic                                  monitor_active_o,
  output logic      [LQT_WARN_W-1:0]            warn_flags_o
);

  logic [LQT_THR_W-1:0]  thr_r [LQT_NUM_THR];
  logic                  sample_en_r;
  logic [2:0]            param_sel_r;
  logic                  hl_sel_r;
  logic [LQT_THR_W-1:0]  data_field_r;
  logic [LQT_THR_W-1:0]  sample_r;
  logic                  sample_req_r;
  logic                  monitor_enable_r;
  logic [LQT_WARN_W-1:0] warn_r;
  logic [LQT_DATA_W-1:0] rdata_r;
  logic                  rvalid_r;

  logic                  wr_data_reg;
  logic                  wr_ctrl_reg;
  logic                  rd_ctrl_reg;
  logic                  sel_valid;
  logic [3:0]            thr_idx;
  logic [LQT_THR_W-1:0]  sel_param_val;
  logic [LQT_THR_W-1:0]  sel_thr_val;
  logic [LQT_WARN_W-1:0] warn_set;

  assign wr_data_reg = reg_wr_i && (reg_addr_i == LQT_THR_DATA_OFS);
  assign wr_ctrl_reg = reg_wr_i && (reg_addr_i == LQT_WARN_CTRL_OFS);
  assign rd_ctrl_reg = reg_rd_i && (reg_addr_i == LQT_WARN_CTRL_OFS);

  assign sel_valid = (param_sel_r <= LQT_SEL_FREQ_CTL);
  assign thr_idx   = {param_sel_r, hl_sel_r};

  always_comb
  begin
    sel_param_val = '0;
    sel_thr_val   = '0;
    if (sel_valid)
    begin
      sel_param_val = param_value_i[param_sel_r*LQT_THR_W +: LQT_THR_W];
      sel_thr_val   = thr_r[thr_idx];
    end
  end

  // Control fields of the threshold data register; the command bit is not kept.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sample_en_r  <= LQT_THR_DATA_RST[LQT_SAMPLE_BIT];
      param_sel_r  <= LQT_THR_DATA_RST[LQT_PSEL_HI:LQT_PSEL_LO];
      hl_sel_r     <= LQT_THR_DATA_RST[LQT_HL_BIT];
      data_field_r <= LQT_THR_DATA_RST[LQT_DATA_HI:0];
    end
    else if (wr_data_reg)
    begin
      sample_en_r  <= reg_wdata_i[LQT_SAMPLE_BIT];
      param_sel_r  <= reg_wdata_i[LQT_PSEL_HI:LQT_PSEL_LO];
      hl_sel_r     <= reg_wdata_i[LQT_HL_BIT];
      data_field_r <= reg_wdata_i[LQT_DATA_HI:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < LQT_NUM_THR; i++)
      begin
        thr_r[i] <= LQT_THR_RST;
      end
    end
    else if (wr_data_reg && reg_wdata_i[LQT_WRCMD_BIT] && !power_down_i &&
             (reg_wdata_i[LQT_PSEL_HI:LQT_PSEL_LO] <= LQT_SEL_FREQ_CTL))
    begin
      thr_r[{reg_wdata_i[LQT_PSEL_HI:LQT_PSEL_LO], reg_wdata_i[LQT_HL_BIT]}] <=
        reg_wdata_i[LQT_DATA_HI:0];
    end
  end

  // A write with the sample bit set starts a new sample, taken one cycle later
  // once the new select has settled.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sample_req_r <= 1'b0;
    end
    else
    begin
      sample_req_r <= wr_data_reg && reg_wdata_i[LQT_SAMPLE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sample_r <= '0;
    end
    else if (sample_req_r)
    begin
      sample_r <= sel_param_val;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      monitor_enable_r <= LQT_WARN_CTRL_RST[LQT_ENABLE_BIT];
    end
    else if (wr_ctrl_reg)
    begin
      monitor_enable_r <= reg_wdata_i[LQT_ENABLE_BIT];
    end
  end

  assign monitor_active_o = monitor_enable_r && link_100_valid_i;

  // Warning bit 2p is the low warning of parameter p, bit 2p+1 the high one.
  always_comb
  begin
    warn_set = '0;
    for (int p = 0; p < LQT_NUM_PARAM; p++)
    begin
      warn_set[2*p]   = monitor_active_o &&
                        (param_value_i[p*LQT_THR_W +: LQT_THR_W] < thr_r[2*p]);
      warn_set[2*p+1] = monitor_active_o &&
                        (param_value_i[p*LQT_THR_W +: LQT_THR_W] > thr_r[2*p+1]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      warn_r <= LQT_WARN_CTRL_RST[LQT_WARN_W-1:0];
    end
    else if (rd_ctrl_reg)
    begin
      warn_r <= warn_set;
    end
    else
    begin
      warn_r <= warn_r | warn_set;
    end
  end

  assign warn_flags_o = warn_r;

  // Read data is registered and marked by a one-cycle valid pulse.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i)
      begin
        rdata_r <= '0;
        if (reg_addr_i == LQT_THR_DATA_OFS)
        begin
          rdata_r[LQT_SAMPLE_BIT]           <= sample_en_r;
          rdata_r[LQT_PSEL_HI:LQT_PSEL_LO]  <= param_sel_r;
          rdata_r[LQT_HL_BIT]               <= hl_sel_r;
          rdata_r[LQT_DATA_HI:0]            <= sample_en_r ? sample_r : sel_thr_val;
        end
        else if (reg_addr_i == LQT_WARN_CTRL_OFS)
        begin
          rdata_r[LQT_ENABLE_BIT]   <= monitor_enable_r;
          rdata_r[LQT_WARN_W-1:0]   <= warn_r;
        end
      end
    end
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;

endmodule : lqt_link_quality_threshold_access
`default_nettype wire

// ---- rtl/lqt_pkg.sv ----
/*
  Package for the link quality threshold access block: register offsets,
  field positions, reset values and parameter select codes.
  Assumes a management register port that carries 5-bit register addresses.
*/
package lqt_pkg;
  localparam int           LQT_ADDR_W      = 5;
  localparam int           LQT_DATA_W      = 16;
  localparam int           LQT_THR_W       = 8;
  localparam int           LQT_NUM_PARAM   = 5;
  localparam int           LQT_NUM_THR     = 10;
  localparam logic [4:0]   LQT_WARN_CTRL_OFS = 5'h1d;
  localparam logic [4:0]   LQT_THR_DATA_OFS  = 5'h1e;
  localparam logic [15:0]  LQT_THR_DATA_RST  = 16'h0000;
  localparam logic [15:0]  LQT_WARN_CTRL_RST = 16'h0000;
  localparam logic [7:0]   LQT_THR_RST       = 8'h00;
  localparam int           LQT_SAMPLE_BIT  = 13;
  localparam int           LQT_WRCMD_BIT   = 12;
  localparam int           LQT_PSEL_HI     = 11;
  localparam int           LQT_PSEL_LO     = 9;
  localparam int           LQT_HL_BIT      = 8;
  localparam int           LQT_DATA_HI     = 7;
  localparam int           LQT_ENABLE_BIT  = 15;
  localparam int           LQT_WARN_W      = 10;
  localparam logic [2:0]   LQT_SEL_EQ_COEF = 3'h0;
  localparam logic [2:0]   LQT_SEL_GAIN    = 3'h1;
  localparam logic [2:0]   LQT_SEL_BLW     = 3'h2;
  localparam logic [2:0]   LQT_SEL_FREQ_OFS = 3'h3;
  localparam logic [2:0]   LQT_SEL_FREQ_CTL = 3'h4;
endpackage : lqt_pkg

// ---- bench/lqt_props.sv ----
/* Port checker for the threshold access block.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module lqt_props
  import lqt_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic [LQT_ADDR_W-1:0] reg_addr_i,
  input wire logic                  reg_rd_i,
  input wire logic [LQT_DATA_W-1:0] reg_rdata_o,
  input wire logic                  reg_rvalid_o,
  input wire logic                  link_100_valid_i,
  input wire logic                  monitor_active_o,
  input wire logic [LQT_WARN_W-1:0] warn_flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_ans;
    ##1 reg_rvalid_o;
  endsequence
  sequence s_warn_rd;
    reg_rd_i && reg_addr_i == LQT_WARN_CTRL_OFS;
  endsequence
  // Bit 15 of the warning register is the enable, so only data register reads count.
  property p_rsv_zero;
    reg_rvalid_o && $past(reg_addr_i) == LQT_THR_DATA_OFS |-> reg_rdata_o[15:14] == 2'h0;
  endproperty
  property p_warn_new;
    (warn_flags_o & ~$past(warn_flags_o)) != '0 |-> $past(monitor_active_o);
  endproperty
  property p_warn_keep;
    !($past(reg_rd_i) && $past(reg_addr_i) == LQT_WARN_CTRL_OFS) |->
      (warn_flags_o & $past(warn_flags_o)) == $past(warn_flags_o);
  endproperty
  AST_RD_ANS: assert property (reg_rd_i |-> s_ans)
    else $error("read not answered");
  AST_RD_ONE: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("stray read valid");
  AST_RSV_ZERO: assert property (p_rsv_zero)
    else $error("reserved bits set");
  AST_WRCMD_ZERO: assert property (reg_rvalid_o |-> !reg_rdata_o[12])
    else $error("command bit read one");
  AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  AST_MON_LINK: assert property (!link_100_valid_i |-> !monitor_active_o)
    else $error("monitor without link");
  AST_WARN_SRC: assert property (p_warn_new)
    else $error("warning while idle");
  AST_WARN_KEEP: assert property (p_warn_keep)
    else $error("warning lost");
  AST_WARN_RD: assert property (s_warn_rd |=> reg_rdata_o[9:0] == $past(warn_flags_o))
    else $error("warnings read wrong");
  AST_WARN_CLR: assert property ((s_warn_rd ##0 !monitor_active_o) |=> warn_flags_o == '0)
    else $error("warnings not cleared");
endmodule : lqt_props
bind lqt_link_quality_threshold_access lqt_props lqt_props_inst (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .link_100_valid_i(link_100_valid_i), .monitor_active_o(monitor_active_o),
  .warn_flags_o(warn_flags_o));
`default_nettype wire

// ---- bench/lqt_mgmt_model.sv ----
/* Management controller model giving one-cycle read and write strobes.
   Assumes the block answers a read exactly one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module lqt_mgmt_model
(
  input  wire logic        clk_i,
  input  wire logic        rvalid_i,
  input  wire logic [15:0] rdata_i,
  output var logic  [4:0]  addr_o,
  output var logic         wr_o,
  output var logic  [15:0] wdata_o,
  output var logic         rd_o
);
  initial {addr_o, wr_o, wdata_o, rd_o} = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    // Released lines show a changed value rather than the last one.
    wdata_o = ~v;
    addr_o = ~a;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] v, output logic ok);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    ok = rvalid_i;
    v = rdata_i;
  endtask : rd
endmodule : lqt_mgmt_model
`default_nettype wire

// ---- bench/lqt_link_quality_threshold_access_bench.sv ----
/* Testbench for the threshold access block.
   Assumes the management model and the port checker bound to the block. */
`timescale 1ns/1ps
`default_nettype none
module lqt_link_quality_threshold_access_bench;
  import lqt_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, pd = 1'b0, link = 1'b0;
  logic [39:0] par = {8'h88, 8'h68, 8'h48, 8'h28, 8'h08};
  logic [15:0] wdata, rdata, d;
  logic [4:0]  addr;
  logic [9:0]  warn;
  logic        wr, rd, rvalid, mon, ok;
  int          n_mismatch = 0;
  int          n_compared = 0;
  always #5 clk_i = ~clk_i;
  lqt_link_quality_threshold_access lqt_link_quality_threshold_access_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .power_down_i(pd),
    .link_100_valid_i(link), .param_value_i(par), .monitor_active_o(mon),
    .warn_flags_o(warn));
  lqt_mgmt_model lqt_mgmt_model_inst (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
    .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
  task automatic results();
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [4:0] a, input logic [15:0] e);
    lqt_mgmt_model_inst.rd(a, d, ok);
    n_compared++;
    if (ok !== 1'b1 || d !== e)
    begin
      n_mismatch++;
      $display("mismatch %0t at %h read %h expected %h", $time, a, d, e);
    end
  endtask : chk
  // The monitor output is not visible through the register port and warning reads clear the flags, so the outputs get their own compare.
  task automatic chk_out(input logic [9:0] ew, input logic em);
    n_compared++;
    if (warn !== ew || mon !== em)
    begin
      n_mismatch++;
      $display("mismatch %0t warnings %h monitor %b", $time, warn, mon);
    end
  endtask : chk_out
  task automatic w(input logic [15:0] v);
    lqt_mgmt_model_inst.wr(LQT_THR_DATA_OFS, v);
  endtask : w
  task automatic t_thr();
    for (int i = 0; i < 10; i++)
      w({4'h1, i[3:0], i[3:0], 4'h0});
    for (int i = 0; i < 10; i++)
    begin
      w({4'h0, i[3:0], 8'h00});
      chk(LQT_THR_DATA_OFS, {4'h0, i[3:0], i[3:0], 4'h0});
    end
  endtask : t_thr
  task automatic t_pd();
    pd = 1'b1;
    w(16'h1155);
    pd = 1'b0;
    w(16'h1a66);
    chk(LQT_THR_DATA_OFS, 16'h0a00);
    w(16'hc100);
    chk(LQT_THR_DATA_OFS, 16'h0110);
  endtask : t_pd
  task automatic t_samp();
    for (int p = 0; p < 5; p++)
    begin
      w({4'h2, p[2:0], 1'b0, 8'h00});
      chk(LQT_THR_DATA_OFS, {4'h2, p[2:0], 1'b0, par[8*p+:8]});
    end
    par[39:32] = 8'h8c;
    chk(LQT_THR_DATA_OFS, 16'h2888);
  endtask : t_samp
  task automatic t_mon();
    lqt_mgmt_model_inst.wr(LQT_WARN_CTRL_OFS, 16'h8000);
    par[23:8] = 16'h30ff;
    chk(LQT_WARN_CTRL_OFS, 16'h8000);
    chk_out(10'h000, 1'b0);
    link = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_out(10'h018, 1'b1);
    // Violations still present at the clearing read set the flags again.
    chk(LQT_WARN_CTRL_OFS, 16'h8018);
    chk(LQT_WARN_CTRL_OFS, 16'h8018);
    par[23:8] = 16'h4828;
    link = 1'b0;
    @(negedge clk_i);
    chk_out(10'h018, 1'b0);
    chk(LQT_WARN_CTRL_OFS, 16'h8018);
    chk(LQT_WARN_CTRL_OFS, 16'h8000);
    chk_out(10'h000, 1'b0);
  endtask : t_mon
  initial
  begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk(LQT_THR_DATA_OFS, 16'h0000);
    chk(5'h00, 16'h0000);
    t_thr();
    t_pd();
    t_samp();
    t_mon();
    results();
  end
endmodule : lqt_link_quality_threshold_access_bench
`default_nettype wire
